// ==== verilog/spibsf_top.sv ====
// Buffer status logic: transmit and receive buffers between the register
// port and a shift register engine; standard (single) or enhanced (FIFO).
// Assumes the shift engine runs on sys_clk and drops sr_ready after sr_load.
`timescale 1ns/1ps
module spibsf_top
	import spibsf_pkg::*;
#(
	parameter bit HAS_ENHANCED = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire spibsf_req_s req,
	output logic [DATA_W-1:0] rdata,
	input wire logic sr_ready,
	input wire spibsf_rx_s sr_rx,
	output logic sr_load,
	output logic [DATA_W-1:0] sr_tx_word,
	output logic word_size_16,
	output logic tx_full,
	output logic rx_full
);

	////////////////////////////////////////////////////////////////////////
	// Storage and state
	logic [DATA_W-1:0] tx_mem [FIFO_DEPTH];
	logic [DATA_W-1:0] rx_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
	logic [CNT_W-1:0] tx_cnt, rx_cnt;
	logic [DATA_W-1:0] control_one;
	logic enhanced, overflow;
	logic [CNT_W-1:0] capacity;
	logic [DATA_W-1:0] word_mask;
	logic wr_data, rd_data, wr_stat, wr_con1;
	logic tx_push, tx_pop, rx_push, rx_pop, mode_change;
	logic [CNT_W-1:0] next_tx_cnt, next_rx_cnt;

	// Bump a pointer around the FIFO ring
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = p + PTR_ONE;
	endfunction : ptr_inc

	////////////////////////////////////////////////////////////////////////
	// Decode and event terms
	always_comb begin
		wr_data = 1'b0;
		rd_data = 1'b0;
		wr_stat = 1'b0;
		wr_con1 = 1'b0;
		if (req.addr == ADDR_DATA) begin
			wr_data = req.wr;
			rd_data = req.rd;
		end else if (req.addr == ADDR_STATUS) begin
			wr_stat = req.wr;
		end else if (req.addr == ADDR_CONTROL_ONE) begin
			wr_con1 = req.wr;
		end
	end

	assign capacity = enhanced ? ENH_CAPACITY : STD_CAPACITY;
	assign word_mask = control_one[CON1_WORD_SIZE] ? WORD_MASK
		: BYTE_MASK; // RULE_10
	assign mode_change = wr_stat && HAS_ENHANCED
		&& (req.wdata[STAT_ENHANCED] != enhanced);
	// Writes into a full transmit buffer are dropped
	assign tx_push = wr_data && (tx_cnt != capacity);
	assign tx_pop = sr_ready && !sr_load && (tx_cnt != CNT_ZERO);
	assign rx_push = sr_rx.valid && (rx_cnt != capacity);
	assign rx_pop = rd_data && (rx_cnt != CNT_ZERO); // RULE_06

	// Occupancy after this cycle's events
	always_comb begin
		next_tx_cnt = tx_cnt;
		next_rx_cnt = rx_cnt;
		if (tx_push && !tx_pop) begin
			next_tx_cnt = tx_cnt + CNT_ONE;
		end else if (tx_pop && !tx_push) begin
			next_tx_cnt = tx_cnt - CNT_ONE;
		end
		if (rx_push && !rx_pop) begin
			next_rx_cnt = rx_cnt + CNT_ONE;
		end else if (rx_pop && !rx_push) begin
			next_rx_cnt = rx_cnt - CNT_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			control_one <= CON1_RESET;
			enhanced <= 1'b0;
		end else begin
			if (wr_con1) begin
				control_one <= req.wdata & CON1_WRITE_MASK;
			end
			if (wr_stat) begin
				enhanced <= HAS_ENHANCED && req.wdata[STAT_ENHANCED]; // RULE_09
			end
		end
	end

	// Overflow: a finished word with no free receive entry is lost
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			overflow <= 1'b0;
		end else if (sr_rx.valid && !rx_push) begin
			overflow <= 1'b1;
		end else if (wr_stat && !req.wdata[STAT_OVERFLOW]) begin
			overflow <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit buffer; one entry in standard mode, eight in enhanced
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_wp <= '0;
			tx_rp <= '0;
			tx_cnt <= CNT_ZERO;
		end else if (mode_change) begin
			tx_wp <= '0;
			tx_rp <= '0;
			tx_cnt <= CNT_ZERO;
		end else begin
			if (tx_push) begin
				tx_wp <= ptr_inc(tx_wp);
			end
			if (tx_pop) begin
				tx_rp <= ptr_inc(tx_rp);
			end
			tx_cnt <= next_tx_cnt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (tx_push) begin
			tx_mem[tx_wp] <= req.wdata & word_mask;
		end
	end

	// Hand the oldest word to the shift register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sr_load <= 1'b0;
			sr_tx_word <= '0;
		end else begin
			sr_load <= tx_pop && !mode_change;
			if (tx_pop) begin
				sr_tx_word <= tx_mem[tx_rp];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive buffer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_cnt <= CNT_ZERO;
		end else if (mode_change) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_cnt <= CNT_ZERO;
		end else begin
			if (rx_push) begin
				rx_wp <= ptr_inc(rx_wp);
			end
			if (rx_pop) begin
				rx_rp <= ptr_inc(rx_rp);
			end
			rx_cnt <= next_rx_cnt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rx_push) begin
			rx_mem[rx_wp] <= sr_rx.word & word_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Full flags follow occupancy; a status write that switches mode clears both
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_full <= 1'b0;
			rx_full <= 1'b0;
		end else if (mode_change) begin
			tx_full <= 1'b0; // RULE_12
			rx_full <= 1'b0;
		end else begin
			// Set on the filling write, clear on the freeing load
			tx_full <= (next_tx_cnt == capacity); // RULE_01 RULE_02 RULE_03 RULE_04
			// Set on the filling transfer, clear on the freeing read
			rx_full <= (next_rx_cnt == capacity); // RULE_05 RULE_06 RULE_07 RULE_08
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			word_size_16 <= 1'b0;
		end else begin
			word_size_16 <= control_one[CON1_WORD_SIZE]; // RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (req.rd) begin
			rdata <= '0;
			if (req.addr == ADDR_STATUS) begin
				rdata[STAT_RX_FULL] <= rx_full;
				rdata[STAT_TX_FULL] <= tx_full;
				rdata[STAT_RX_EMPTY] <= enhanced
					&& (rx_cnt == CNT_ZERO); // RULE_11 RULE_09
				rdata[STAT_OVERFLOW] <= overflow;
				rdata[STAT_ENHANCED] <= enhanced; // RULE_09
			end else if (req.addr == ADDR_CONTROL_ONE) begin
				rdata <= control_one;
			end else if (req.addr == ADDR_DATA) begin
				if (rx_cnt != CNT_ZERO) begin
					rdata <= rx_mem[rx_rp];
				end
			end
		end
	end

endmodule : spibsf_top

// ==== verilog/spibsf_pkg.sv ====
// Constants, register map and carrier types of the buffer status block.
// Assumes one 200 MHz clock and a register port with one-cycle read data.
// Behaviour
// RULE_01: Standard mode: a data-location write loads the buffer and sets tx full.
// RULE_02: Standard mode: tx full clears when the word moves into the shifter.
// RULE_03: Enhanced mode: tx full sets when a write fills the last FIFO entry.
// RULE_04: Enhanced mode: tx full clears once any tx FIFO entry is free.
// RULE_05: Standard mode: rx full sets when a finished word enters the buffer.
// RULE_06: Standard mode: reading the data location empties it and clears rx full.
// RULE_07: Enhanced mode: rx full sets when a word fills the last rx entry.
// RULE_08: Enhanced mode: rx full clears once an rx entry is free again.
// RULE_09: Without enhanced support the enhanced-only status bits read as zero.
// RULE_10: Word size bit set gives 16-bit words, clear gives 8-bit words.
// RULE_11: Enhanced mode: rx empty bit reads 1 when the rx FIFO holds nothing.
// RULE_12: Both full flags are read-only and follow only hardware events; a status write that switches mode also clears both.
package spibsf_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] STD_CAPACITY = 4'h1;
	localparam logic [CNT_W-1:0] ENH_CAPACITY = 4'h8;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h08;

	// serial_status_control fields
	localparam int STAT_RX_FULL = 0;
	localparam int STAT_TX_FULL = 1;
	localparam int STAT_RX_EMPTY = 5;
	localparam int STAT_OVERFLOW = 6;
	localparam int STAT_ENHANCED = 14;

	// serial_control_one fields
	localparam int CON1_WORD_SIZE = 10;
	localparam logic [DATA_W-1:0] CON1_WRITE_MASK = 16'h1FFF;
	localparam logic [DATA_W-1:0] CON1_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00FF;
	localparam logic [DATA_W-1:0] WORD_MASK = 16'hFFFF;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} spibsf_req_s;

	// Word handed over by the shift register after a transfer
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] word;
	} spibsf_rx_s;
endpackage : spibsf_pkg

// ==== tb/spibsf_checker.sv ====
// Port assertions for the buffer status block.
// Bound into spibsf_top; sees only its ports.
`timescale 1ns/1ps
module spibsf_checker
	import spibsf_pkg::*;
#(
	parameter bit HAS_ENHANCED = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire spibsf_req_s req,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic sr_ready,
	input wire spibsf_rx_s sr_rx,
	input wire logic sr_load,
	input wire logic [DATA_W-1:0] sr_tx_word,
	input wire logic word_size_16,
	input wire logic tx_full,
	input wire logic rx_full
);
	logic enh, dwr, drd, swr;
	// Strobes on the data and status places
	assign dwr = req.wr && req.addr == ADDR_DATA;
	assign drd = req.rd && req.addr == ADDR_DATA;
	assign swr = req.wr && req.addr == ADDR_STATUS;
	// Follows the selected buffer operation
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			enh <= 1'b0;
		else if (swr)
			enh <= req.wdata[STAT_ENHANCED] & HAS_ENHANCED;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_tx_set: assert property (!enh && dwr && !tx_full |=> tx_full)
		else $error("tx full not set");
	chk_load_clr: assert property (sr_load && !$past(dwr) |-> !tx_full)
		else $error("tx full kept on load");
	// An empty buffer takes the finished word; a mode switch flushes instead
	chk_rx_set: assert property (!enh && !swr && sr_rx.valid && !rx_full
		|=> rx_full)
		else $error("rx full not set");
	chk_rx_clr: assert property (drd && rx_full && !sr_rx.valid |=> !rx_full)
		else $error("rx full kept on read");
	chk_tx_rise: assert property ($rose(tx_full) |-> $past(dwr))
		else $error("tx full rose alone");
	chk_rx_rise: assert property ($rose(rx_full) |-> $past(sr_rx.valid))
		else $error("rx full rose alone");
	chk_tx_fall: assert property ($fell(tx_full) |-> sr_load || $past(swr))
		else $error("tx full fell alone");
	// Stored bit lands one cycle after the write, its copy one cycle later
	chk_word_size: assert property (req.wr && req.addr == ADDR_CONTROL_ONE
		|-> ##2 word_size_16 == $past(req.wdata[CON1_WORD_SIZE], 2))
		else $error("word size wrong");
endmodule : spibsf_checker

bind spibsf_top spibsf_checker #(.HAS_ENHANCED(HAS_ENHANCED)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
	.sr_ready(sr_ready), .sr_rx(sr_rx), .sr_load(sr_load),
	.sr_tx_word(sr_tx_word), .word_size_16(word_size_16),
	.tx_full(tx_full), .rx_full(rx_full));

// ==== tb/spibsf_engine.sv ====
// Shift engine model: takes a word on sr_load, returns its inverse.
// Runs on sys_clk; hold keeps it from taking words.
`timescale 1ns/1ps
module spibsf_engine
	import spibsf_pkg::*;
#(
	parameter int LEN = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hold,
	input wire logic sr_load,
	input wire logic [DATA_W-1:0] sr_tx_word,
	output logic sr_ready,
	output spibsf_rx_s sr_rx
);
	int cnt;
	logic [DATA_W-1:0] last;
	// Busy LEN cycles per word; idle word lines toggle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			last <= '0;
			sr_ready <= 1'b0;
			sr_rx <= '0;
		end else begin
			sr_rx.valid <= (cnt == 1);
			sr_rx.word <= (cnt == 1) ? ~last : ~sr_rx.word;
			if (sr_load) begin
				cnt <= LEN;
				last <= sr_tx_word;
				sr_ready <= 1'b0;
			end else if (cnt != 0)
				cnt <= cnt - 1;
			else
				sr_ready <= !hold;
		end
	end
endmodule : spibsf_engine

// ==== tb/spibsf_test.sv ====
// Self-checking bench for the buffer status block.
// Register port driven here; engine model on the shift side.
`timescale 1ns/1ps
module spibsf_test
	import spibsf_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic hold = 1'b1;
	spibsf_req_s req = '0;
	spibsf_rx_s sr_rx;
	logic [DATA_W-1:0] rdata, sr_tx_word;
	logic sr_ready, sr_load, word_size_16, tx_full, rx_full;
	int err_count = 0;
	int checked = 0;
	int j;
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	spibsf_top u_dut (.sys_clk(sys_clk), .rst(rst), .req(req),
		.rdata(rdata), .sr_ready(sr_ready), .sr_rx(sr_rx),
		.sr_load(sr_load), .sr_tx_word(sr_tx_word),
		.word_size_16(word_size_16), .tx_full(tx_full), .rx_full(rx_full));
	spibsf_engine u_eng (.sys_clk(sys_clk), .rst(rst), .hold(hold),
		.sr_load(sr_load), .sr_tx_word(sr_tx_word), .sr_ready(sr_ready),
		.sr_rx(sr_rx));
	task automatic check(input logic [15:0] seen, exp, input string what);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One-cycle write (w=1) or read; returns in the read data cycle
	task automatic acc(input logic [7:0] a, input logic [15:0] d, input logic w);
		@(posedge sys_clk);
		req <= '{a, d, w, !w};
		@(posedge sys_clk);
		req <= '0;
		#1;
	endtask : acc
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (2000) @(posedge sys_clk);
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		acc(ADDR_STATUS, 0, 0);
		check(rdata, 16'h0000, "status");
		acc(ADDR_CONTROL_ONE, 16'hFFFF, 1);
		// Word size output copies the stored bit one cycle later
		acc(8'h0C, 0, 0);
		check(rdata, 16'h0000, "unmapped");
		check(word_size_16, 1, "word size");
		acc(ADDR_CONTROL_ONE, 16'h0000, 0);
		check(rdata, 16'h1FFF, "control");
		// Standard buffer, byte words
		acc(ADDR_CONTROL_ONE, 16'h0000, 1);
		acc(ADDR_DATA, 16'hA5C3, 1);
		check(tx_full, 1, "tx full");
		check(word_size_16, 0, "word size");
		acc(ADDR_STATUS, 16'h0000, 1);
		check(tx_full, 1, "tx full");
		acc(ADDR_STATUS, 0, 0);
		check(rdata, 16'h0002, "status");
		@(posedge sys_clk) hold <= 1'b0;
		for (j = 0; j < 99 && tx_full !== 1'b0; j++) @(negedge sys_clk);
		check(tx_full, 0, "tx full");
		check(sr_tx_word, 16'h00C3, "tx word");
		for (j = 0; j < 99 && rx_full !== 1'b1; j++) @(negedge sys_clk);
		check(rx_full, 1, "rx full");
		acc(ADDR_DATA, 0, 0);
		check(rx_full, 0, "rx full");
		check(rdata, 16'h003C, "rx word");
		$display("standard test done");
		// Enhanced buffer, 16-bit words
		@(posedge sys_clk) hold <= 1'b1;
		acc(ADDR_CONTROL_ONE, 16'h0400, 1);
		acc(ADDR_STATUS, 16'h4000, 1);
		for (int k = 0; k < 9; k++) begin
			check(tx_full, k == 8, "tx full");
			acc(ADDR_DATA, 16'h1100 + k, 1);
		end
		@(posedge sys_clk) hold <= 1'b0;
		for (j = 0; j < 99 && tx_full !== 1'b0; j++) @(negedge sys_clk);
		check(tx_full, 0, "tx full");
		for (j = 0; j < 99 && rx_full !== 1'b1; j++) @(negedge sys_clk);
		check(rx_full, 1, "rx full");
		acc(ADDR_STATUS, 0, 0);
		check(rdata, 16'h4001, "status");
		for (int k = 0; k < 8; k++) begin
			acc(ADDR_DATA, 0, 0);
			check(rdata, ~(16'h1100 + k), "rx word");
			check(rx_full, 0, "rx full");
		end
		acc(ADDR_STATUS, 0, 0);
		check(rdata, 16'h4020, "status");
		$display("enhanced test done");
		wrap_up();
	end
endmodule : spibsf_test
